/* File: asbi_card.sv */
// Purpose: behavioural accessory card on the slot
// Assumes: card samples slot lines on clk_sys
// Notes: answers qualified memory reads, may hold wait low
module asbi_card (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic [7:0] wait_len,
   input  wire logic [7:0] addr_low,
   input  wire logic [7:0] data_o,
   input  wire logic       sel_n,
   input  wire logic       strobe,
   input  wire logic       io_n_mem,
   input  wire logic       dir,
   output logic      [7:0] data_i,
   output logic            wait_n,
   output logic            wr_stb,
   output logic      [7:0] wr_data
);
   timeunit 1ns;
   timeprecision 100ps;
   logic       drv_q;
   logic       strobe_q;
   logic [7:0] wcnt_q;
   logic       qual;
   // select is glitchy in T1, so it only counts with the strobe
   assign qual = strobe && !sel_n && !io_n_mem;
   assign wait_n = (wcnt_q == 8'h00);
   always_ff @(posedge clk_sys) begin
      strobe_q <= strobe;
      wr_stb   <= strobe_q && !strobe && !sel_n && dir;
      wr_data  <= data_o;
      if (rst || sel_n) drv_q <= 1'b0;
      else if (qual && !dir) drv_q <= 1'b1;
      // released bus toggles so a stale value never passes
      if (rst) data_i <= 8'h00;
      else data_i <= drv_q ? (addr_low ^ 8'h5a) : ~data_i;
      if (rst) wcnt_q <= 8'h00;
      else if (qual && !strobe_q) wcnt_q <= wait_len;
      else if (wcnt_q != 8'h00) wcnt_q <= wcnt_q - 8'h01;
   end
endmodule

/* File: asbi_host.sv */
// Purpose: host end of the accessory slot bus: runs one bus cycle per request
// Assumes: requests come from logic on clk_sys; slot lines from outside
// Notes: bus states advance on rising edges of the derived 8 MHz clock
`include "asbi_params.svh"
module asbi_host (
   input  wire logic              clk_sys,
   input  wire logic              rst,
   // request side
   input  wire logic              req_valid,
   input  wire asbi_pkg::asbi_req_t req,
   output logic                   req_ready,
   output logic                   rsp_valid,
   output logic [7:0]             rsp_rdata,
   input  wire logic              hold_grant,
   input  wire logic              board_full,
   output logic                   comm_irq,
   output logic                   sys_irq,
   // slot pins
   output logic                   slot_bus_clock,
   output logic                   slot_reset_n,
   output logic [7:0]             slot_addr_low,
   output logic [3:0]             slot_addr_mid,
   output logic [7:0]             slot_addr_high,
   input  wire logic [7:0]        slot_data_i,
   output logic [7:0]             slot_data_o,
   output logic                   slot_data_oe,
   output logic                   slot_read_n,
   output logic                   slot_write_n,
   output logic                   cycle_status_line,
   output logic                   io_not_mem,
   output logic                   xfer_direction,
   output logic                   addr_qual_strobe,
   output logic                   slot_one_select_n,
   output logic                   slot_two_select_n,
   output logic                   hold_ack_sync,
   output logic                   mem_size_flag,
   input  wire logic              wait_request_n,
   input  wire logic              shared_comm_irq_n,
   input  wire logic              system_irq_n
);
   // -------------------------------------------------------------
   // functions
   // -------------------------------------------------------------
   function automatic logic asbi_is_write(input asbi_pkg::asbi_kind_t k);
      return (k == asbi_pkg::asbi_mem_wr) || (k == asbi_pkg::asbi_io_wr);
   endfunction

   function automatic logic asbi_is_io(input asbi_pkg::asbi_kind_t k);
      return (k == asbi_pkg::asbi_io_rd) || (k == asbi_pkg::asbi_io_wr);
   endfunction

   // -------------------------------------------------------------
   // input synchronisers
   // -------------------------------------------------------------
   logic [2:0] sync_out;
   logic [7:0] data_sync;

   asbi_sync #(.W(3)) u_sync_ctl (
      .clk_sys (clk_sys),
      .rst     (rst),
      .din     ({wait_request_n, shared_comm_irq_n, system_irq_n}),
      .dout    (sync_out)
   );

   asbi_sync #(.W(8)) u_sync_data (
      .clk_sys (clk_sys),
      .rst     (rst),
      .din     (slot_data_i),
      .dout    (data_sync)
   );

   // interrupt lines are active low; a low level is the request
   assign comm_irq = ~sync_out[1];
   assign sys_irq  = ~sync_out[0];

   // -------------------------------------------------------------
   // bus clock divider and power-on reset
   // -------------------------------------------------------------
   logic [3:0]  div_q,  div_d;
   logic        bclk_q, bclk_d;
   logic [7:0]  rcnt_q, rcnt_d;
   logic        rstn_q, rstn_d;
   logic        rise;

   always_comb begin
      div_d  = div_q + 4'h1;
      bclk_d = bclk_q;
      if (div_q == 4'((`ASBI_HALF_CYC) - 1)) begin
         div_d  = 4'h0;
         bclk_d = ~bclk_q;
      end
      rcnt_d = rcnt_q;
      rstn_d = rstn_q;
      if (rcnt_q != 8'(`ASBI_RESET_CYC))
         rcnt_d = rcnt_q + 8'h01;
      else
         rstn_d = 1'b1;
   end

   assign rise = (div_q == 4'((`ASBI_HALF_CYC) - 1)) && !bclk_q;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         div_q  <= 4'h0;
         bclk_q <= 1'b0;
         rcnt_q <= 8'h00;
         rstn_q <= 1'b0;
      end else begin
         div_q  <= div_d;
         bclk_q <= bclk_d;
         rcnt_q <= rcnt_d;
         rstn_q <= rstn_d;
      end
   end

   assign slot_bus_clock = bclk_q;
   assign slot_reset_n   = rstn_q;

   // -------------------------------------------------------------
   // bus cycle sequencer
   // -------------------------------------------------------------
   asbi_pkg::asbi_tstate_t st_q, st_d;
   asbi_pkg::asbi_req_t    cur_q, cur_d;
   logic       go_q, go_d;
   logic       rd_q, rd_d;
   logic       wr_q, wr_d;
   logic       oe_q, oe_d;
   logic       sel1_q, sel1_d;
   logic       sel2_q, sel2_d;
   logic       rv_q, rv_d;
   logic [7:0] rdat_q, rdat_d;
   logic       hack_q, hack_d;
   logic [4:0] hcnt_q, hcnt_d;
   logic       size_q, size_d;

   assign req_ready = (st_q == asbi_pkg::asbi_idle) && rstn_q && !hack_q;

   always_comb begin
      st_d   = st_q;
      cur_d  = cur_q;
      go_d   = go_q;
      rd_d   = rd_q;
      wr_d   = wr_q;
      oe_d   = oe_q;
      sel1_d = sel1_q;
      sel2_d = sel2_q;
      rv_d   = 1'b0;
      rdat_d = rdat_q;
      hack_d = hack_q;
      hcnt_d = hcnt_q;
      size_d = board_full;
      if (req_valid && req_ready) begin
         cur_d = req;
         st_d  = asbi_pkg::asbi_t1;
      end
      if (rise) begin
         unique case (st_q)
            asbi_pkg::asbi_t1: begin
               st_d = asbi_pkg::asbi_t2;
               go_d = 1'b1;
               rd_d = !asbi_is_write(cur_q.kind);
               wr_d = asbi_is_write(cur_q.kind);
               oe_d = asbi_is_write(cur_q.kind);
            end
            asbi_pkg::asbi_t2: st_d = asbi_pkg::asbi_t3;
            asbi_pkg::asbi_t3, asbi_pkg::asbi_tw: begin
               // keep inserting waits while a card holds the line low
               if (!sync_out[2])
                  st_d = asbi_pkg::asbi_tw;
               else begin
                  st_d   = asbi_pkg::asbi_t4;
                  go_d   = 1'b0;
                  rd_d   = 1'b0;
                  wr_d   = 1'b0;
                  rdat_d = data_sync;
                  rv_d   = !asbi_is_write(cur_q.kind);
               end
            end
            asbi_pkg::asbi_t4: begin
               st_d   = asbi_pkg::asbi_idle;
               oe_d   = 1'b0;
               sel1_d = 1'b0;
               sel2_d = 1'b0;
               rv_d   = asbi_is_write(cur_q.kind);
            end
            asbi_pkg::asbi_idle: ;
         endcase
      end
      if (st_q == asbi_pkg::asbi_t1) begin
         // select only for memory cycles in the slot's 64K page
         sel1_d = !asbi_is_io(cur_q.kind) && cur_q.addr[19:16] == `ASBI_SLOT1_PAGE;
         sel2_d = !asbi_is_io(cur_q.kind) && cur_q.addr[19:16] == `ASBI_SLOT2_PAGE;
      end
      // hold acknowledge changes only on bus clock edges, fixed width
      if (rise) begin
         if (hack_q) begin
            if (hcnt_q == 5'(`ASBI_HOLD_ACK_BUSCYC - 1)) begin
               hack_d = 1'b0;
               hcnt_d = 5'h00;
            end else
               hcnt_d = hcnt_q + 5'h01;
         end else if (hold_grant && st_q == asbi_pkg::asbi_idle && !(req_valid && req_ready))
            hack_d = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_q   <= asbi_pkg::asbi_idle;
         cur_q  <= '0;
         go_q   <= 1'b0;
         rd_q   <= 1'b0;
         wr_q   <= 1'b0;
         oe_q   <= 1'b0;
         sel1_q <= 1'b0;
         sel2_q <= 1'b0;
         rv_q   <= 1'b0;
         rdat_q <= 8'h00;
         hack_q <= 1'b0;
         hcnt_q <= 5'h00;
         size_q <= 1'b0;
      end else begin
         st_q   <= st_d;
         cur_q  <= cur_d;
         go_q   <= go_d;
         rd_q   <= rd_d;
         wr_q   <= wr_d;
         oe_q   <= oe_d;
         sel1_q <= sel1_d;
         sel2_q <= sel2_d;
         rv_q   <= rv_d;
         rdat_q <= rdat_d;
         hack_q <= hack_d;
         hcnt_q <= hcnt_d;
         size_q <= size_d;
      end
   end

   // -------------------------------------------------------------
   // slot outputs
   // -------------------------------------------------------------
   assign slot_addr_low     = cur_q.addr[7:0];
   assign slot_addr_mid     = cur_q.addr[11:8];
   assign slot_addr_high    = cur_q.addr[19:12];
   assign slot_data_o       = cur_q.wdata;
   assign slot_data_oe      = oe_q;
   assign slot_read_n       = ~rd_q;
   assign slot_write_n      = ~wr_q;
   assign io_not_mem        = asbi_is_io(cur_q.kind);
   assign xfer_direction    = asbi_is_write(cur_q.kind);
   assign cycle_status_line = ~(cur_q.kind == asbi_pkg::asbi_io_rd);
   assign addr_qual_strobe  = go_q;
   // first select to the left module, second to the right
   assign slot_one_select_n = ~sel1_q;
   assign slot_two_select_n = ~sel2_q;
   assign hold_ack_sync     = hack_q;
   assign mem_size_flag     = size_q;
   assign rsp_valid         = rv_q;
   assign rsp_rdata         = rdat_q;
endmodule

/* File: asbi_monitor.sv */
// Purpose: checker on the host slot pins
// Assumes: one clk_sys domain, sync active-high rst
// Notes: bound to asbi_host below
module asbi_monitor (
   input wire logic       clk_sys,
   input wire logic       rst,
   input wire logic       req_ready,
   input wire logic       comm_irq,
   input wire logic       slot_reset_n,
   input wire logic [7:0] slot_addr_high,
   input wire logic       slot_read_n,
   input wire logic       slot_write_n,
   input wire logic       io_not_mem,
   input wire logic       xfer_direction,
   input wire logic       addr_qual_strobe,
   input wire logic       slot_one_select_n,
   input wire logic       slot_two_select_n,
   input wire logic       hold_ack_sync,
   input wire logic       wait_request_n,
   input wire logic       shared_comm_irq_n,
   input wire logic       slot_bus_clock,
   input wire logic       slot_data_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----
   // properties
   // ----
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_wait_held;
      !wait_request_n [*5];
   endsequence
   sequence s_hold_start;
      $rose(hold_ack_sync);
   endsequence
   sequence s_bus_edge;
      $rose(slot_bus_clock);
   endsequence
   strobe_window_a: assert property (
      addr_qual_strobe |-> !(slot_read_n && slot_write_n)) else $error("strobe alone");
   read_dir_a: assert property (
      $fell(slot_read_n) |-> !xfer_direction) else $error("read with write direction");
   write_dir_a: assert property (
      $fell(slot_write_n) |-> xfer_direction) else $error("write with read direction");
   slot_one_a: assert property (
      !slot_one_select_n |-> !io_not_mem && slot_addr_high[7:4] == 4'h9)
      else $error("slot one select outside block");
   slot_two_a: assert property (
      !slot_two_select_n |-> !io_not_mem && slot_addr_high[7:4] == 4'ha)
      else $error("slot two select outside block");
   select_excl_a: assert property (
      slot_one_select_n || slot_two_select_n) else $error("both selects low");
   wait_stretch_a: assert property (
      s_wait_held |-> !$fell(addr_qual_strobe)) else $error("cycle ended during wait");
   hold_span_a: assert property (
      s_hold_start |=> hold_ack_sync [*8]) else $error("hold ack too short");
   hold_busy_a: assert property (
      hold_ack_sync |-> !req_ready) else $error("request taken during hold");
   reset_quiet_a: assert property (
      !slot_reset_n |-> !req_ready && slot_read_n && slot_write_n)
      else $error("activity during slot reset");
   comm_irq_a: assert property (
      !shared_comm_irq_n [*4] |-> comm_irq) else $error("comm interrupt missed");
   strobe_edge_a: assert property (
      $changed(addr_qual_strobe) |-> s_bus_edge) else $error("strobe off bus edge");
   read_release_a: assert property (
      !slot_read_n |-> !slot_data_oe) else $error("host drives data in read");
   data_drive_a: assert property (
      !slot_write_n |-> slot_data_oe) else $error("host not driving write data");
endmodule
bind asbi_host asbi_monitor u_asbi_monitor (.clk_sys, .rst, .req_ready, .comm_irq,
   .slot_reset_n, .slot_addr_high, .slot_read_n, .slot_write_n, .io_not_mem,
   .xfer_direction, .addr_qual_strobe, .slot_one_select_n, .slot_two_select_n,
   .hold_ack_sync, .wait_request_n, .shared_comm_irq_n, .slot_bus_clock,
   .slot_data_oe);

/* File: asbi_params.svh */
// Purpose: constants for the host end of the accessory slot bus
// Assumes: clk_sys at 100 MHz; slot bus clock is 8 MHz derived here
// Notes on behaviour
// - strobe high from T2 until T4
// - low wait request stretches cycle with waits
// - select only inside slot's 64K block
// - select one left module, two right
// - drive memory versus io indicator
// - drive direction indicator each cycle
// - read strobe low during read cycle
// - write strobe low during write cycle
// - present 20-bit address and 8-bit data
// - supply buffered 8 MHz bus clock
// - low shared comm line is that interrupt
// - low system interrupt line requests service
// - drive hold acknowledge synced to bus clock
// - assert slot reset at power-on
// - size flag 0 for 128K, 1 for 256K
// - slot one 09xxxxH, slot two 0Axxxxh
`ifndef ASBI_PARAMS_SVH
`define ASBI_PARAMS_SVH
`define ASBI_SYS_PERIOD_NS   10
`define ASBI_BUS_PERIOD_NS   125
`define ASBI_HALF_CYC        ((`ASBI_BUS_PERIOD_NS / `ASBI_SYS_PERIOD_NS) / 2)
`define ASBI_SLOT1_PAGE      4'h9
`define ASBI_SLOT2_PAGE      4'ha
`define ASBI_RESET_NS        1000
`define ASBI_RESET_CYC       (`ASBI_RESET_NS / `ASBI_SYS_PERIOD_NS)
`define ASBI_HOLD_ACK_NS     2500
`define ASBI_HOLD_ACK_BUSCYC (`ASBI_HOLD_ACK_NS / `ASBI_BUS_PERIOD_NS)
`endif

/* File: asbi_pkg.sv */
// Purpose: types for the accessory slot bus host end
// Assumes: nothing
// Notes: requests travel as a packed struct; kinds and bus states are enums
package asbi_pkg;
   typedef enum logic [1:0] {
      asbi_mem_rd,
      asbi_mem_wr,
      asbi_io_rd,
      asbi_io_wr
   } asbi_kind_t;

   typedef struct packed {
      asbi_kind_t  kind;
      logic [19:0] addr;
      logic [7:0]  wdata;
   } asbi_req_t;

   typedef enum logic [2:0] {
      asbi_t1,
      asbi_t2,
      asbi_t3,
      asbi_tw,
      asbi_t4,
      asbi_idle
   } asbi_tstate_t;
endpackage

/* File: asbi_sync.sv */
// Purpose: two-flop synchroniser for slot-side inputs
// Assumes: inputs come from outside clk_sys
// Notes: first stage is read only by the second stage
module asbi_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;
   logic [W-1:0] sync_d;

   always_comb begin
      meta_d = din;
      sync_d = meta_q;
   end

   // reset to released (high) level, the idle level of the active-low control lines
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         meta_q <= '1;
         sync_q <= '1;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign dout = sync_q;
endmodule

/* File: asbi_tb.sv */
// Purpose: self-checking bench for the slot bus host end
// Assumes: one card model on either select, irq lines driven here
// Notes: driver queues expectations, a watcher checks them
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic                clk_sys = 1'b0;
   logic                rst = 1'b1;
   logic                req_valid = 1'b0;
   asbi_pkg::asbi_req_t req = '0;
   logic                hold_grant = 1'b0;
   logic                board_full = 1'b0;
   logic                shared_comm_irq_n = 1'b1;
   logic                system_irq_n = 1'b1;
   logic [7:0]          wait_len = 8'h00;
   logic req_ready, rsp_valid, comm_irq, sys_irq, slot_bus_clock, slot_reset_n, slot_data_oe;
   logic slot_read_n, slot_write_n, cycle_status_line, io_not_mem, xfer_direction;
   logic addr_qual_strobe, slot_one_select_n, slot_two_select_n, hold_ack_sync;
   logic mem_size_flag, wait_request_n, wr_stb;
   logic [7:0] rsp_rdata, slot_addr_low, slot_addr_high, slot_data_i, slot_data_o, wr_data;
   logic [3:0] slot_addr_mid;
   logic [8:0] note_q[$];
   logic [7:0] wq[$];
   logic [8:0] nt;
   int         n_fail = 0;
   int         n_compared = 0;
   int         i;
   int         n;
   asbi_host u_asbi_host (
      .clk_sys           (clk_sys),
      .rst               (rst),
      .req_valid         (req_valid),
      .req               (req),
      .req_ready         (req_ready),
      .rsp_valid         (rsp_valid),
      .rsp_rdata         (rsp_rdata),
      .hold_grant        (hold_grant),
      .board_full        (board_full),
      .comm_irq          (comm_irq),
      .sys_irq           (sys_irq),
      .slot_bus_clock    (slot_bus_clock),
      .slot_reset_n      (slot_reset_n),
      .slot_addr_low     (slot_addr_low),
      .slot_addr_mid     (slot_addr_mid),
      .slot_addr_high    (slot_addr_high),
      .slot_data_i       (slot_data_i),
      .slot_data_o       (slot_data_o),
      .slot_data_oe      (slot_data_oe),
      .slot_read_n       (slot_read_n),
      .slot_write_n      (slot_write_n),
      .cycle_status_line (cycle_status_line),
      .io_not_mem        (io_not_mem),
      .xfer_direction    (xfer_direction),
      .addr_qual_strobe  (addr_qual_strobe),
      .slot_one_select_n (slot_one_select_n),
      .slot_two_select_n (slot_two_select_n),
      .hold_ack_sync     (hold_ack_sync),
      .mem_size_flag     (mem_size_flag),
      .wait_request_n    (wait_request_n),
      .shared_comm_irq_n (shared_comm_irq_n),
      .system_irq_n      (system_irq_n)
   );
   asbi_card u_asbi_card (.clk_sys(clk_sys), .rst(rst), .wait_len(wait_len),
      .addr_low(slot_addr_low), .data_o(slot_data_o),
      .sel_n(slot_one_select_n & slot_two_select_n), .strobe(addr_qual_strobe),
      .io_n_mem(io_not_mem), .dir(xfer_direction), .data_i(slot_data_i),
      .wait_n(wait_request_n), .wr_stb(wr_stb), .wr_data(wr_data));
   always #5 clk_sys = ~clk_sys;
   // ----
   // checking
   // ----
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wait_for(ref logic s, input logic v, output int k);
      for (k = 0; s !== v; k++) begin
         if (k == 1000) begin
            n_fail++;
            $display("ERROR %0t: wait ran out", $time);
            complete_run();
         end
         @(negedge clk_sys);
      end
   endtask
   always @(negedge clk_sys) begin
      if (rsp_valid === 1'b1) begin
         nt = (note_q.size() > 0) ? note_q.pop_front() : 9'h1ff;
         if (nt[8]) check(rsp_rdata, nt[7:0]);
      end
      if (wr_stb === 1'b1) check(wr_data, (wq.size() > 0) ? wq.pop_front() : 9'h1ff);
   end
   // ----
   // stimulus
   // ----
   task automatic bus_op(input asbi_pkg::asbi_kind_t k, input logic [19:0] a,
                         input logic [7:0] w);
      logic rd;
      logic mem;
      logic s1;
      logic s2;
      int   c;
      @(negedge clk_sys);
      rd  = (k == asbi_pkg::asbi_mem_rd) || (k == asbi_pkg::asbi_io_rd);
      mem = (k == asbi_pkg::asbi_mem_rd) || (k == asbi_pkg::asbi_mem_wr);
      s1  = mem && a[19:16] == 4'h9;
      s2  = mem && a[19:16] == 4'ha;
      wait_len  = w;
      req       = '{kind: k, addr: a, wdata: 8'($urandom)};
      req_valid = 1'b1;
      note_q.push_back({rd && (s1 || s2), a[7:0] ^ 8'h5a});
      if (!rd && (s1 || s2)) wq.push_back(req.wdata);
      wait_for(req_ready, 1'b1, c);
      @(negedge clk_sys);
      req_valid = 1'b0;
      wait_for(addr_qual_strobe, 1'b1, c);
      check({slot_addr_high, slot_addr_mid, slot_addr_low}, a);
      check({io_not_mem, xfer_direction}, {!mem, !rd});
      check({slot_read_n, slot_write_n}, {!rd, rd});
      check({slot_one_select_n, slot_two_select_n}, {!s1, !s2});
      check(cycle_status_line, !(rd && !mem));
      check(slot_data_oe, !rd);
      wait_for(addr_qual_strobe, 1'b0, c);
      if (s1 || s2) check(c > w, 1'b1);
   endtask
   initial begin
      void'($urandom(36));
      repeat (8) @(posedge clk_sys);
      @(negedge clk_sys);
      rst = 1'b0;
      check(slot_reset_n, 1'b0);
      wait_for(slot_reset_n, 1'b1, n);
      check(n >= 100 && n <= 102, 1'b1);
      wait_for(slot_bus_clock, 1'b1, n);
      wait_for(slot_bus_clock, 1'b0, n);
      check(n, 6);
      $display("test done: reset and bus clock");
      for (i = 0; i < 8; i++) bus_op(asbi_pkg::asbi_kind_t'(i % 4),
                                     {(i < 4) ? 4'h9 : 4'ha, 16'($urandom)}, 8'(i * 9));
      bus_op(asbi_pkg::asbi_mem_rd, 20'h8ffff, 8'h00);
      bus_op(asbi_pkg::asbi_mem_wr, 20'hb0000, 8'h00);
      $display("test done: bus cycles");
      @(negedge clk_sys);
      hold_grant = 1'b1;
      wait_for(hold_ack_sync, 1'b1, n);
      hold_grant = 1'b0;
      check(req_ready, 1'b0);
      wait_for(hold_ack_sync, 1'b0, n);
      check(n >= 228 && n <= 252, 1'b1);
      $display("test done: hold");
      for (i = 0; i < 2; i++) begin
         board_full = i[0];
         shared_comm_irq_n = i[0];
         system_irq_n = !i[0];
         repeat (4) @(negedge clk_sys);
         check({mem_size_flag, comm_irq, sys_irq}, {i[0], !i[0], i[0]});
      end
      check(note_q.size() + wq.size(), 0);
      $display("test done: flags and interrupts");
      complete_run();
   end
endmodule
